// ### core/smp_consts.svh
// Constants for the serial master/slave port
// Overview of operation
// - As master, the port leads every transfer; select goes low first.
// - Data runs master-to-slave on master-out, slave-to-master on master-in.
// - Both ends shift their bytes toward each other at the same time.
// - Master may raise select after each byte to realign the slave.
// - Master: clock, master-out are outputs, select only with select disable; master-in is input.
// - Slave: clock, master-out, select are inputs; master-in is output.
// - Link uses three pins, four with the select line.
// - Master offers seven clock rates from divider select and doubler.
// - Doubled fastest master clock is system clock divided by two.
// - Bit order selects least or most significant bit first.
// - A transfer-done flag is raised in master mode only and can request an interrupt.
// - Unbuffered data write during a shift raises a write collision flag.
// - Port keeps running in idle sleep and can wake the system.
// - Port runs during debugging but stops while the CPU is halted.
// - Select disable in master mode turns off multimaster detection.
// - All logic, slave clock sampling included, runs on one clock.
// - Master write starts eight-bit shift; when idle, flags set.
// - Select driven low while master forces slave mode and a flag.
// - Slave with select high tri-states master-in, drops partial byte.
// - Two-bit mode picks clock polarity and phase; opposite edges.
`ifndef SMP_CONSTS_SVH
`define SMP_CONSTS_SVH
// ==========================================================
// Clock and timing
`define SMP_CLK_PERIOD_NS 10
`define SMP_SCK_MIN_PHASE_CYC 2
// ==========================================================
// Master half-period counts, in system clocks
`define SMP_HALF_DIV2 7'h01
`define SMP_HALF_DIV4 7'h02
`define SMP_HALF_DIV8 7'h04
`define SMP_HALF_DIV16 7'h08
`define SMP_HALF_DIV32 7'h10
`define SMP_HALF_DIV64 7'h20
`define SMP_HALF_DIV128 7'h40
// ==========================================================
// Divider select codes
`define SMP_CLOCK_DIVIDER_SELECT_4 2'h0
`define SMP_CLOCK_DIVIDER_SELECT_16 2'h1
`define SMP_CLOCK_DIVIDER_SELECT_64 2'h2
`define SMP_CLOCK_DIVIDER_SELECT_128 2'h3
// ==========================================================
// Shift geometry and pin order
`define SMP_LAST_BIT 3'h7
`define SMP_LAST_EDGE 4'hF
`define SMP_PIN_SCK 0
`define SMP_PIN_MOSI 1
`define SMP_PIN_MISO 2
`define SMP_PIN_SS 3
`endif

// ### core/smp_pkg.sv
// Types for the serial master/slave port
package smp_pkg;
   // ==========================================================
   // Configuration bits
   typedef struct packed {
      logic enable;
      logic master;
      logic rate_doubler;
      logic [1:0] clock_divider_select;
      logic bit_order_select;
      logic [1:0] mode;
      logic buffering_on;
      logic buffer_first_write_ctl;
      logic select_line_disable;
   } smp_ctrl_t;
   // ==========================================================
   // Event flags
   typedef struct packed {
      logic rx_done_flag;
      logic transfer_done_flag;
      logic tx_empty_flag;
      logic select_takeover_flag;
      logic write_collision_flag;
      logic rx_overflow_flag;
   } smp_flags_t;
   typedef enum logic {SMP_IDLE, SMP_SHIFT} smp_state_t;
endpackage

// ### core/smp_port.sv
// Serial master/slave port: shifter, clock generator, pin control
`timescale 1ns/1ps
`default_nettype none
`include "smp_consts.svh"
module smp_port (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire smp_pkg::smp_ctrl_t i_ctrl,
   input wire logic i_dbg_halt,
   input wire logic i_wr_valid,
   input wire logic [7:0] i_wr_data,
   input wire smp_pkg::smp_flags_t i_flag_clr,
   input wire logic i_sel_level,
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_miso,
   input wire logic i_ss_b,
   output logic o_sck,
   output logic o_sck_oe_b,
   output logic o_mosi,
   output logic o_mosi_oe_b,
   output logic o_miso,
   output logic o_miso_oe_b,
   output logic o_ss_b,
   output logic o_ss_oe_b,
   output logic [7:0] o_rx_data,
   output smp_pkg::smp_flags_t o_flags,
   output logic o_master_active,
   output logic o_wake_req
);
   // ==========================================================
   // Helpers
   function automatic logic first_bit(input logic [7:0] v,
                                      input logic lsb_first);
      first_bit = lsb_first ? v[0] : v[7];
   endfunction

   function automatic logic [6:0] half_count(input logic [1:0] sel,
                                             input logic dbl);
      logic [6:0] h;
      h = `SMP_HALF_DIV128;
      unique case (sel)
         `SMP_CLOCK_DIVIDER_SELECT_4: h = dbl ? `SMP_HALF_DIV2 : `SMP_HALF_DIV4;
         `SMP_CLOCK_DIVIDER_SELECT_16: h = dbl ? `SMP_HALF_DIV8 : `SMP_HALF_DIV16;
         `SMP_CLOCK_DIVIDER_SELECT_64: h = dbl ? `SMP_HALF_DIV32 : `SMP_HALF_DIV64;
         `SMP_CLOCK_DIVIDER_SELECT_128: h = dbl ? `SMP_HALF_DIV64 : `SMP_HALF_DIV128;
      endcase
      half_count = h;
   endfunction

   // ==========================================================
   // Declarations
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic sck_d_reg;
   logic master_reg;
   logic master_cfg_d_reg;
   smp_pkg::smp_state_t state_reg;
   logic [6:0] div_cnt_reg;
   logic [3:0] edge_cnt_reg;
   logic sck_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] sh_reg;
   logic out_reg;
   logic [7:0] tx_buf_reg;
   logic tx_pending_reg;
   logic [7:0] rx_reg;
   smp_pkg::smp_flags_t flags_reg;
   logic run;
   logic cpol;
   logic cpha;
   logic lsb_first;
   logic sck_s;
   logic ss_s;
   logic in_bit;
   logic m_tick;
   logic s_edge;
   logic lead_ev;
   logic samp_ev;
   logic launch_ev;
   logic byte_end;
   logic busy;
   logic takeover;
   logic load_idle;
   logic load_sh;
   logic [7:0] load_val;
   logic [7:0] sh_shift;
   logic [1:0] msamp_reg;
   logic [7:0] rx_sh_reg;
   logic rx_take;
   logic rx_end;
   logic [7:0] rx_shift;

   // Halt freezes the clock generator and shifter in place; disable returns to idle
   assign run = i_ctrl.enable & ~i_dbg_halt;
   assign cpol = i_ctrl.mode[1];
   assign cpha = i_ctrl.mode[0];
   assign lsb_first = i_ctrl.bit_order_select;
   assign sck_s = sync2_reg[`SMP_PIN_SCK];
   assign ss_s = sync2_reg[`SMP_PIN_SS];
   assign in_bit = master_reg ? sync2_reg[`SMP_PIN_MISO]
                              : sync2_reg[`SMP_PIN_MOSI];

   // ==========================================================
   // Input synchronisers, all on the one system clock
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         sync1_reg <= 4'hF;
         sync2_reg <= 4'hF;
         // Same level as the synchroniser, so no false edge after reset
         sck_d_reg <= 1'b1;
      end
      else
      begin
         sync1_reg <= {i_ss_b, i_miso, i_mosi, i_sck};
         sync2_reg <= sync1_reg;
         sck_d_reg <= sck_s;
      end
   end

   // ==========================================================
   // Edge events, common to both roles
   assign m_tick = master_reg && state_reg == smp_pkg::SMP_SHIFT &&
      div_cnt_reg == half_count(i_ctrl.clock_divider_select,
                                i_ctrl.rate_doubler) - 7'h01;
   // Slave sees clock edges only while selected
   assign s_edge = !master_reg && !ss_s && sck_s != sck_d_reg;
   assign lead_ev = run &&
      ((m_tick && sck_reg == cpol) ||
       (s_edge && sck_d_reg == cpol));
   assign samp_ev = run && (m_tick || s_edge) &&
      (lead_ev ^ cpha);
   assign launch_ev = run && (m_tick || s_edge) && !samp_ev;
   assign byte_end = master_reg ?
      (run && m_tick && edge_cnt_reg == `SMP_LAST_EDGE) :
      (samp_ev && bit_cnt_reg == `SMP_LAST_BIT);
   assign sh_shift = lsb_first ? {in_bit, sh_reg[7:1]}
                               : {sh_reg[6:0], in_bit};
   // Master takes returning data two clocks late: the pin synchroniser
   // delay, which would otherwise lose bits at the fastest rates
   assign rx_take = run && (master_reg ? msamp_reg[1] : samp_ev);
   assign rx_shift = lsb_first ? {in_bit, rx_sh_reg[7:1]}
                               : {rx_sh_reg[6:0], in_bit};
   assign rx_end = rx_take && bit_cnt_reg == `SMP_LAST_BIT;
   assign busy = master_reg ? state_reg == smp_pkg::SMP_SHIFT
                            : (!ss_s && bit_cnt_reg != 3'h0);
   // Multimaster detection, off when the select line is disabled
   assign takeover = run && master_reg &&
      !i_ctrl.select_line_disable && !ss_s;
   // The dummy buffered slave mode waits for a finished byte
   assign load_idle = run && tx_pending_reg && !busy &&
      (master_reg ? state_reg == smp_pkg::SMP_IDLE
                  : (!i_ctrl.buffering_on ||
                     i_ctrl.buffer_first_write_ctl || ss_s));
   assign load_sh = load_idle || (byte_end && tx_pending_reg);
   assign load_val = tx_buf_reg;

   // ==========================================================
   // Role: follows software, dropped on takeover
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         master_reg <= 1'b0;
         master_cfg_d_reg <= 1'b0;
      end
      else
      begin
         master_cfg_d_reg <= i_ctrl.master;
         if (!i_ctrl.enable)
            master_reg <= i_ctrl.master;
         else if (takeover)
            master_reg <= 1'b0;
         else if (i_ctrl.master != master_cfg_d_reg)
            master_reg <= i_ctrl.master;
      end
   end

   // ==========================================================
   // Master clock generator
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_reg <= smp_pkg::SMP_IDLE;
         div_cnt_reg <= 7'h00;
         edge_cnt_reg <= 4'h0;
         sck_reg <= 1'b0;
      end
      else if (!i_ctrl.enable || takeover || !master_reg)
      begin
         state_reg <= smp_pkg::SMP_IDLE;
         div_cnt_reg <= 7'h00;
         edge_cnt_reg <= 4'h0;
         sck_reg <= cpol;
      end
      else if (run)
      begin
         unique case (state_reg)
            smp_pkg::SMP_IDLE:
            begin
               sck_reg <= cpol;
               div_cnt_reg <= 7'h00;
               edge_cnt_reg <= 4'h0;
               if (load_idle)
                  state_reg <= smp_pkg::SMP_SHIFT;
            end
            smp_pkg::SMP_SHIFT:
            begin
               if (m_tick)
               begin
                  div_cnt_reg <= 7'h00;
                  sck_reg <= ~sck_reg;
                  edge_cnt_reg <= edge_cnt_reg + 4'h1;
                  if (byte_end && !tx_pending_reg)
                     state_reg <= smp_pkg::SMP_IDLE;
               end
               else
                  div_cnt_reg <= div_cnt_reg + 7'h01;
            end
         endcase
      end
   end

   // ==========================================================
   // Shifter and bit counter
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         sh_reg <= 8'h00;
         out_reg <= 1'b0;
         bit_cnt_reg <= 3'h0;
         msamp_reg <= 2'h0;
         rx_sh_reg <= 8'h00;
      end
      else if (!i_ctrl.enable)
      begin
         bit_cnt_reg <= 3'h0;
         msamp_reg <= 2'h0;
      end
      else if (run)
      begin
         msamp_reg <= {msamp_reg[0], samp_ev && master_reg};
         if ((!master_reg && ss_s) || takeover)
            bit_cnt_reg <= 3'h0;
         else if (rx_take)
         begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_sh_reg <= rx_shift;
         end
         if (load_sh)
         begin
            sh_reg <= load_val;
            out_reg <= first_bit(load_val, lsb_first);
         end
         else if (samp_ev)
            sh_reg <= sh_shift;
         else if (launch_ev)
            out_reg <= first_bit(sh_reg, lsb_first);
      end
   end

   // ==========================================================
   // Transmit buffer and received byte
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         tx_buf_reg <= 8'h00;
         tx_pending_reg <= 1'b0;
         rx_reg <= 8'h00;
      end
      else if (!i_ctrl.enable)
         tx_pending_reg <= 1'b0;
      else
      begin
         // Unbuffered writes during a shift are refused
         if (i_wr_valid && (i_ctrl.buffering_on || !busy))
         begin
            tx_buf_reg <= i_wr_data;
            tx_pending_reg <= 1'b1;
         end
         else if (load_sh)
            tx_pending_reg <= 1'b0;
         if (rx_end)
            rx_reg <= rx_shift;
      end
   end

   // ==========================================================
   // Flags; a set in the clearing cycle wins
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         flags_reg <= '0;
      else
      begin
         flags_reg.rx_done_flag <= rx_end ||
            (flags_reg.rx_done_flag && !i_flag_clr.rx_done_flag);
         flags_reg.transfer_done_flag <=
            (byte_end && master_reg && !tx_pending_reg) ||
            (flags_reg.transfer_done_flag &&
             !i_flag_clr.transfer_done_flag);
         flags_reg.tx_empty_flag <= load_sh ||
            (flags_reg.tx_empty_flag && !i_wr_valid &&
             !i_flag_clr.tx_empty_flag);
         flags_reg.select_takeover_flag <= takeover ||
            (flags_reg.select_takeover_flag &&
             !i_flag_clr.select_takeover_flag);
         flags_reg.write_collision_flag <=
            (run && i_wr_valid && busy && !i_ctrl.buffering_on) ||
            (flags_reg.write_collision_flag &&
             !i_flag_clr.write_collision_flag);
         flags_reg.rx_overflow_flag <=
            (rx_end && flags_reg.rx_done_flag &&
             !i_flag_clr.rx_done_flag) ||
            (flags_reg.rx_overflow_flag &&
             !i_flag_clr.rx_overflow_flag);
      end
   end

   // ==========================================================
   // Pin drivers, registered; enables are low while driving
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_sck_oe_b <= 1'b1;
         o_mosi_oe_b <= 1'b1;
         o_miso_oe_b <= 1'b1;
         o_ss_oe_b <= 1'b1;
         o_ss_b <= 1'b1;
         o_wake_req <= 1'b0;
      end
      else
      begin
         o_sck_oe_b <= !(i_ctrl.enable && master_reg);
         o_mosi_oe_b <= !(i_ctrl.enable && master_reg);
         o_miso_oe_b <= !(i_ctrl.enable && !master_reg &&
                          !ss_s);
         // Select is driven only when not watched for other masters
         o_ss_oe_b <= !(i_ctrl.enable && master_reg &&
                        i_ctrl.select_line_disable);
         o_ss_b <= i_sel_level;
         o_wake_req <= |flags_reg;
      end
   end

   assign o_sck = sck_reg;
   assign o_mosi = out_reg;
   assign o_miso = out_reg;
   assign o_rx_data = rx_reg;
   assign o_flags = flags_reg;
   assign o_master_active = master_reg;

   // ==========================================================
   // Checks
   sequence s_start;
      run && master_reg && !takeover &&
      state_reg == smp_pkg::SMP_IDLE && tx_pending_reg;
   endsequence
   sequence s_shifting;
      state_reg == smp_pkg::SMP_SHIFT && flags_reg.tx_empty_flag;
   endsequence

   property p_start;
      @(posedge i_clk) disable iff (!i_rst_b)
      s_start |=> s_shifting;
   endproperty
   a_start: assert property (p_start)
      else $error("master did not start on pending data");

   property p_done;
      @(posedge i_clk) disable iff (!i_rst_b)
      byte_end && master_reg && !tx_pending_reg && !takeover
         |=> state_reg == smp_pkg::SMP_IDLE &&
             flags_reg.transfer_done_flag;
   endproperty
   a_done: assert property (p_done)
      else $error("transfer done not flagged at idle");

   property p_takeover;
      @(posedge i_clk) disable iff (!i_rst_b)
      takeover |=> !master_reg && flags_reg.select_takeover_flag
         ##1 o_sck_oe_b;
   endproperty
   a_takeover: assert property (p_takeover)
      else $error("select takeover not handled");

   property p_ss_drop;
      @(posedge i_clk) disable iff (!i_rst_b)
      run && !master_reg && ss_s
         |=> bit_cnt_reg == 3'h0 && o_miso_oe_b;
   endproperty
   a_ss_drop: assert property (p_ss_drop)
      else $error("slave active while deselected");

   property p_wrcol;
      @(posedge i_clk) disable iff (!i_rst_b)
      run && i_wr_valid && busy && !i_ctrl.buffering_on
         |=> flags_reg.write_collision_flag &&
             tx_buf_reg == $past(tx_buf_reg);
   endproperty
   a_wrcol: assert property (p_wrcol)
      else $error("write collision missed");

   property p_fastest;
      @(posedge i_clk) disable iff (!i_rst_b)
      run && master_reg && !takeover && i_ctrl.rate_doubler &&
      i_ctrl.clock_divider_select == `SMP_CLOCK_DIVIDER_SELECT_4 &&
      state_reg == smp_pkg::SMP_SHIFT |=> sck_reg != $past(sck_reg);
   endproperty
   a_fastest: assert property (p_fastest)
      else $error("fastest rate not half the clock");

   property p_halt;
      @(posedge i_clk) disable iff (!i_rst_b)
      i_ctrl.enable && i_dbg_halt
         |=> $stable(sh_reg) && $stable(bit_cnt_reg) &&
             $stable(sck_reg);
   endproperty
   a_halt: assert property (p_halt)
      else $error("port moved while halted");

   property p_disabled;
      @(posedge i_clk) disable iff (!i_rst_b)
      !i_ctrl.enable[*2] |-> o_sck_oe_b && o_mosi_oe_b &&
         o_miso_oe_b && state_reg == smp_pkg::SMP_IDLE;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("disabled port still active");

   property p_order;
      @(posedge i_clk) disable iff (!i_rst_b)
      run && load_sh |=> out_reg == (i_ctrl.bit_order_select ?
         $past(load_val[0]) : $past(load_val[7]));
   endproperty
   a_order: assert property (p_order)
      else $error("wrong first bit for bit order");
endmodule
`default_nettype wire

// ### verif/smp_port_test.sv
// Self-checking bench for the serial master/slave port
`timescale 1ns/1ps
`default_nettype none
module smp_port_test;
   // ==========================================================
   // Signals and wiring
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   smp_pkg::smp_ctrl_t ctrl = '0;
   smp_pkg::smp_flags_t flag_clr = '0;
   smp_pkg::smp_flags_t o_flags;
   logic dbg_halt = 1'b0;
   logic wr_valid = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic sel_level = 1'b1;
   logic tb_sck = 1'b0;
   logic tb_mosi = 1'b0;
   logic tb_ss_b = 1'b1;
   logic [7:0] slv_tx = 8'h00;
   logic o_sck, o_sck_oe_b, o_mosi, o_mosi_oe_b, o_miso, o_miso_oe_b;
   logic o_ss_b, o_ss_oe_b, o_master_active, o_wake_req, m_miso;
   logic [7:0] o_rx_data;
   logic [7:0] m_rx;
   int n_mismatch = 0;
   int cmp_count = 0;
   wire logic sck_w = !o_sck_oe_b ? o_sck : tb_sck;
   wire logic mosi_w = !o_mosi_oe_b ? o_mosi : tb_mosi;
   wire logic miso_w = !o_miso_oe_b ? o_miso : m_miso;
   wire logic ss_w = !o_ss_oe_b ? o_ss_b : tb_ss_b;
   always #5 i_clk = ~i_clk;
   // Undriven data line toggles so a stale level never matches
   always @(posedge i_clk)
      if (tb_ss_b)
         tb_mosi <= ~tb_mosi;
   smp_port dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ctrl(ctrl),
      .i_dbg_halt(dbg_halt), .i_wr_valid(wr_valid), .i_wr_data(wr_data),
      .i_flag_clr(flag_clr), .i_sel_level(sel_level), .i_sck(sck_w),
      .i_mosi(mosi_w), .i_miso(miso_w), .i_ss_b(ss_w), .o_sck(o_sck),
      .o_sck_oe_b(o_sck_oe_b), .o_mosi(o_mosi), .o_mosi_oe_b(o_mosi_oe_b),
      .o_miso(o_miso), .o_miso_oe_b(o_miso_oe_b), .o_ss_b(o_ss_b),
      .o_ss_oe_b(o_ss_oe_b), .o_rx_data(o_rx_data), .o_flags(o_flags),
      .o_master_active(o_master_active), .o_wake_req(o_wake_req));
   smp_slave_model slv_u (.i_sck(sck_w), .i_mosi(mosi_w), .i_ss_b(ss_w),
      .i_mode(ctrl.mode), .i_tx(slv_tx), .o_miso(m_miso), .o_rx(m_rx));
   // ==========================================================
   // Helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int k = 0; k < 8; k++)
         rev[k] = v[7 - k];
   endfunction
   function automatic smp_pkg::smp_ctrl_t mk(input logic ms, input logic db,
      input logic [1:0] dv, input logic lsb, input logic [1:0] md,
      input logic sd);
      mk = '0;
      mk.enable = 1'b1;
      mk.master = ms;
      mk.rate_doubler = db;
      mk.clock_divider_select = dv;
      mk.bit_order_select = lsb;
      mk.mode = md;
      mk.select_line_disable = sd;
   endfunction
   // Enable goes last, after the rest has settled
   task automatic cfg(input smp_pkg::smp_ctrl_t c);
      smp_pkg::smp_ctrl_t c0;
      c0 = c;
      c0.enable = 1'b0;
      ctrl <= c0;
      flag_clr <= '1;
      tick(2);
      flag_clr <= '0;
      ctrl <= c;
      tick(3);
   endtask
   task automatic wr(input logic [7:0] d);
      wr_valid <= 1'b1;
      wr_data <= d;
      tick(1);
      wr_valid <= 1'b0;
   endtask
   task automatic wait_tc();
      int n;
      n = 0;
      while (o_flags.transfer_done_flag !== 1'b1 && n < 3000)
      begin
         @(negedge i_clk);
         n++;
      end
      // Received byte lands up to two clocks after the last edge
      tick(3);
   endtask
   // ==========================================================
   // Scenarios
   task automatic xfer(input smp_pkg::smp_ctrl_t c, input logic [7:0] tx,
      input logic [7:0] sx, input logic halt);
      int moves;
      logic last;
      moves = 0;
      cfg(c);
      slv_tx <= sx;
      sel_level <= 1'b0;
      tick(3);
      wr(tx);
      tick(4);
      check(8'(o_ss_b), 8'h00);
      check(8'(o_sck_oe_b | o_mosi_oe_b | !o_miso_oe_b), 8'h00);
      if (halt)
      begin
         dbg_halt <= 1'b1;
         tick(2);
         @(negedge i_clk);
         last = o_sck;
         repeat (60)
         begin
            @(negedge i_clk);
            if (o_sck !== last)
               moves++;
         end
         @(posedge i_clk);
         dbg_halt <= 1'b0;
         check(8'(moves), 8'h00);
      end
      wait_tc();
      check(8'(o_flags.transfer_done_flag), 8'h01);
      check(8'(o_flags.tx_empty_flag), 8'h01);
      check(o_rx_data, c.bit_order_select ? rev(sx) : sx);
      check(m_rx, c.bit_order_select ? rev(tx) : tx);
      check(8'(o_master_active), 8'h01);
      check(8'(o_wake_req), 8'h01);
      sel_level <= 1'b1;
      tick(2);
   endtask
   task automatic t_rates();
      int half [8] = '{2, 1, 8, 4, 32, 16, 64, 32};
      int n;
      logic last;
      for (int r = 0; r < 8; r++)
      begin
         cfg(mk(1'b1, r[0], r[2:1], 1'b0, 2'h0, 1'b1));
         sel_level <= 1'b0;
         wr(8'h96);
         @(negedge i_clk);
         last = o_sck;
         for (n = 0; n < 300 && o_sck === last; n++)
            @(negedge i_clk);
         last = o_sck;
         for (n = 0; n < 300 && o_sck === last; n++)
            @(negedge i_clk);
         check(8'(n), 8'(half[r]));
         wait_tc();
         sel_level <= 1'b1;
      end
   endtask
   task automatic t_collide();
      cfg(mk(1'b1, 1'b0, 2'h1, 1'b0, 2'h0, 1'b1));
      sel_level <= 1'b0;
      tick(1);
      wr(8'h5E);
      tick(20);
      wr(8'h21);
      tick(2);
      check(8'(o_flags.write_collision_flag), 8'h01);
      wait_tc();
      check(m_rx, 8'h5E);
      sel_level <= 1'b1;
      tick(2);
   endtask
   // Buffered back-to-back bytes; second byte of the far side is all ones
   task automatic t_buffered();
      smp_pkg::smp_ctrl_t c;
      c = mk(1'b1, 1'b1, 2'h0, 1'b0, 2'h0, 1'b1);
      c.buffering_on = 1'b1;
      cfg(c);
      slv_tx <= 8'h01;
      sel_level <= 1'b0;
      tick(3);
      wr(8'h3C);
      tick(1);
      wr(8'hA5);
      wait_tc();
      check(8'(o_flags.write_collision_flag), 8'h00);
      check(8'(o_flags.rx_overflow_flag), 8'h01);
      check(o_rx_data, 8'hFF);
      check(m_rx, 8'hA5);
      sel_level <= 1'b1;
      tick(2);
   endtask
   task automatic t_takeover();
      cfg(mk(1'b1, 1'b0, 2'h1, 1'b0, 2'h0, 1'b0));
      check(8'(o_ss_oe_b), 8'h01);
      tb_ss_b <= 1'b0;
      tick(6);
      check(8'(o_master_active), 8'h00);
      check(8'(o_flags.select_takeover_flag), 8'h01);
      check(8'(o_sck_oe_b), 8'h01);
      tb_ss_b <= 1'b1;
      tick(2);
   endtask
   task automatic t_off();
      smp_pkg::smp_ctrl_t c;
      c = mk(1'b1, 1'b1, 2'h0, 1'b0, 2'h0, 1'b1);
      c.enable = 1'b0;
      cfg(c);
      wr(8'h7E);
      tb_ss_b <= 1'b0;
      tick(40);
      check(8'(o_sck_oe_b & o_mosi_oe_b), 8'h01);
      check({2'b00, o_flags}, 8'h00);
      tb_ss_b <= 1'b1;
      tick(2);
   endtask
   // Each clock phase lasts four system clocks, above the minimum
   task automatic sbyte(input logic [7:0] mo, input int nb,
      output logic [7:0] mi);
      mi = 8'h00;
      tb_ss_b <= 1'b0;
      tick(4);
      for (int k = 0; k < nb; k++)
      begin
         tb_mosi <= mo[7 - k];
         tb_sck <= 1'b0;
         tick(4);
         mi = {mi[6:0], miso_w};
         tb_sck <= 1'b1;
         tick(4);
      end
      tb_sck <= 1'b0;
      tick(5);
   endtask
   task automatic t_slave();
      logic [7:0] got;
      cfg(mk(1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0));
      sbyte(8'hFF, 3, got);
      tb_ss_b <= 1'b1;
      tick(6);
      check(8'(o_miso_oe_b), 8'h01);
      check({2'b00, o_flags}, 8'h00);
      wr(8'h4D);
      tick(2);
      sbyte(8'hB2, 8, got);
      check(8'(o_miso_oe_b | !o_sck_oe_b), 8'h00);
      check(o_rx_data, 8'hB2);
      check(got, 8'h4D);
      tb_ss_b <= 1'b1;
      tick(2);
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial
   begin
      tick(5);
      check(8'(o_sck_oe_b & o_mosi_oe_b & o_miso_oe_b), 8'h01);
      i_rst_b <= 1'b1;
      tick(2);
      for (int m = 0; m < 8; m++)
         xfer(mk(1'b1, 1'b1, 2'h0, m[2], m[1:0], 1'b1), 8'hC1 + 8'(m),
            8'h36 + 8'(m), 1'b0);
      t_rates();
      xfer(mk(1'b1, 1'b0, 2'h1, 1'b0, 2'h3, 1'b1), 8'hE4, 8'h1B, 1'b1);
      t_collide();
      t_buffered();
      t_takeover();
      t_off();
      t_slave();
      test_done();
   end
   // Whole run needs well under twenty thousand cycles
   initial
   begin
      repeat (60000) @(posedge i_clk);
      n_mismatch++;
      test_done();
   end
endmodule
`default_nettype wire

// ### verif/smp_slave_model.sv
// Behavioural serial slave facing the port in master mode
`timescale 1ns/1ps
`default_nettype none
module smp_slave_model (
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_ss_b,
   input wire logic [1:0] i_mode,
   input wire logic [7:0] i_tx,
   output logic o_miso,
   output logic [7:0] o_rx
);
   // ==========================================================
   // Shifter
   // Raw MSB-first on purpose, so bit order shows in the bench
   logic [7:0] sh;
   int n_out;
   initial
   begin
      o_miso = 1'b0;
      o_rx = 8'h00;
      n_out = 0;
   end
   always @(negedge i_ss_b)
   begin
      sh = i_tx;
      n_out = 0;
      if (!i_mode[0])
      begin
         o_miso = sh[7];
         n_out = 1;
      end
   end
   // Released line must not keep a stale level
   always @(posedge i_ss_b)
      o_miso = ~o_miso;
   always @(i_sck)
   begin
      if (!i_ss_b)
      begin
         if ((i_sck != i_mode[1]) ^ i_mode[0])
            o_rx = {o_rx[6:0], i_mosi};
         else if (n_out < 8)
         begin
            o_miso = sh[7 - n_out];
            n_out = n_out + 1;
         end
      end
   end
endmodule
`default_nettype wire
